// >>> hw/primary_fuse_programming.sv
/*
 * Paged register front of the primary fuse store: page select, subsystem force power-up,
 * per-page fuse lock and fuse write command, and the manual wake-up control.
 * Assumes a byte register port already decoded by the serial management interface,
 * running on ref_clk; the fuse macro itself sits outside and takes a start pulse and page.
 */
`timescale 1ns/1ps
// What this block does
// - Force-override bits 0..6 take forced subsystem control.
// - Enable bits 0..6 power the matching subsystem.
// - Lock field value 01 locks that page's fuse.
// - Pages 0,1,2,3,a..d map to their subsystems.
// - Command 5'h0c in bits 7:3 starts fuse write.
// - Slaves stay in manual wake-up while programming.
// - Page 0 bit 4 of fuse_lock_and_wake_control disables manual wake-up.
// - Page select write switches page; read returns it.
module primary_fuse_programming #(
    parameter int BURN_LEN = fuse_prog_pkg::BURN_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    output logic [fuse_prog_pkg::NUM_SUBSYS-1:0] forceOverride,
    output logic [fuse_prog_pkg::NUM_SUBSYS-1:0] subsysPowerEn,
    output logic manualWakeMode,
    output logic fuseWriteStart,
    output logic [2:0] fuseWritePage,
    output logic fuseWriteBusy
);
    import fuse_prog_pkg::*;

    typedef enum logic [1:0] {
        IDLE = 2'b01,
        BURN = 2'b10
    } burn_state_t;

    page_store_if storeBus ();

    page_reg_store u_store (
        .ref_clk(ref_clk),
        .rst(rst),
        .bus(storeBus)
    );

    burn_state_t state_r, state_nxt;
    logic [31:0] burnCnt_r, burnCnt_nxt;
    logic [7:0] page_r, page_nxt;
    logic [2:0] slot_r, slot_nxt;
    logic [NUM_SUBSYS-1:0] force_r, force_nxt;
    logic [NUM_SUBSYS-1:0] powerEn_r, powerEn_nxt;
    logic wakeOff_r, wakeOff_nxt;
    logic manualWake_r, manualWake_nxt;
    logic start_r, start_nxt;
    logic [2:0] burnPage_r, burnPage_nxt;
    logic busy_r, busy_nxt;
    logic [7:0] rdData_r, rdData_nxt;
    logic rdValid_r, rdValid_nxt;
    logic [3:0] newSlot;
    logic onMaster;
    logic cmdHit;
    logic hitPage;
    logic hitCmd;
    logic hitLock;
    logic hitForce;
    logic hitPower;

    assign newSlot = page_slot(regWrData);
    assign onMaster = slot_r == MASTER_IDX;
    // Both the field form and the full-byte form of the command are taken.
    assign cmdHit = regWrData[CMD_MSB:CMD_LSB] == FUSE_WRITE_CMD || regWrData == FUSE_WRITE_BYTE;
    assign hitPage = regAddr == PAGE_SEL_ADDR;
    assign hitCmd = regAddr == FUSE_CMD_ADDR;
    assign hitLock = regAddr == LOCK_WAKE_ADDR;
    // The power controls live on the master page only, so a slave page cannot switch itself off.
    assign hitForce = onMaster && regAddr == FORCE_OVR_ADDR;
    assign hitPower = onMaster && regAddr == PWR_EN_ADDR;

    assign storeBus.wrEn = regWrEn && (hitCmd || hitLock);
    assign storeBus.selLock = hitLock;
    assign storeBus.slot = slot_r;
    assign storeBus.wrData = regWrData;

    always_comb begin
        page_nxt = page_r;
        slot_nxt = slot_r;
        force_nxt = force_r;
        powerEn_nxt = powerEn_r;
        wakeOff_nxt = wakeOff_r;
        if (regWrEn) begin
            if (hitPage && newSlot[3]) begin
                // Unknown page codes are dropped so the store index always stays legal.
                page_nxt = regWrData;
                slot_nxt = newSlot[2:0];
            end
            if (hitForce) begin
                force_nxt = regWrData[NUM_SUBSYS-1:0];
            end
            if (hitPower) begin
                powerEn_nxt = regWrData[NUM_SUBSYS-1:0];
            end
            // Wake-off is sticky until reset; manual wake-up drops on the same edge that sets it, except during a burn.
            if (onMaster && hitLock && regWrData[WAKE_OFF_BIT]) begin
                wakeOff_nxt = 1'b1;
            end
        end
    end

    always_comb begin
        state_nxt = state_r;
        burnCnt_nxt = burnCnt_r;
        start_nxt = 1'b0;
        burnPage_nxt = burnPage_r;
        case (state_r)
            IDLE: begin
                if (regWrEn && hitCmd && cmdHit && !storeBus.lockedVec[slot_r]) begin
                    state_nxt = BURN;
                    start_nxt = 1'b1;
                    burnPage_nxt = slot_r;
                    burnCnt_nxt = 32'(BURN_LEN - 1);
                end
            end
            BURN: begin
                // Further commands during a burn are dropped; the macro serves one page at a time.
                if (burnCnt_r == 32'd0) begin
                    state_nxt = IDLE;
                end else begin
                    burnCnt_nxt = burnCnt_r - 32'd1;
                end
            end
            default: begin
                state_nxt = IDLE;
            end
        endcase
        busy_nxt = state_nxt == BURN;
        manualWake_nxt = !wakeOff_nxt || busy_nxt;
    end

    always_comb begin
        rdData_nxt = rdData_r;
        rdValid_nxt = regRdEn;
        if (regRdEn) begin
            case (regAddr)
                PAGE_SEL_ADDR: rdData_nxt = page_r;
                FUSE_CMD_ADDR: begin
                    rdData_nxt = storeBus.cmdData;
                    rdData_nxt[BUSY_BIT] = busy_r;
                end
                LOCK_WAKE_ADDR: rdData_nxt = storeBus.lockData;
                FORCE_OVR_ADDR: rdData_nxt = onMaster ? {1'b0, force_r} : 8'h00;
                PWR_EN_ADDR: rdData_nxt = onMaster ? {1'b0, powerEn_r} : 8'h00;
                default: rdData_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            page_r <= PAGE_RESET;
            slot_r <= MASTER_IDX;
            force_r <= '0;
            powerEn_r <= '0;
            wakeOff_r <= 1'b0;
        end else begin
            page_r <= page_nxt;
            slot_r <= slot_nxt;
            force_r <= force_nxt;
            powerEn_r <= powerEn_nxt;
            wakeOff_r <= wakeOff_nxt;
        end
    end

    // Busy and the wake hold sit in one bank so they always move on the same edge.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= IDLE;
            burnCnt_r <= 32'd0;
            manualWake_r <= 1'b1;
            start_r <= 1'b0;
            burnPage_r <= MASTER_IDX;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            burnCnt_r <= burnCnt_nxt;
            manualWake_r <= manualWake_nxt;
            start_r <= start_nxt;
            burnPage_r <= burnPage_nxt;
            busy_r <= busy_nxt;
        end
    end

    // Read data hold until the next read, so a slow host can still pick them up.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdData_r <= REG_RESET;
            rdValid_r <= 1'b0;
        end else begin
            rdData_r <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign regRdValid = rdValid_r;
    assign forceOverride = force_r;
    assign subsysPowerEn = powerEn_r;
    assign manualWakeMode = manualWake_r;
    assign fuseWriteStart = start_r;
    assign fuseWritePage = burnPage_r;
    assign fuseWriteBusy = busy_r;
endmodule

// >>> hw/fuse_prog_pkg.sv
/*
 * Constants for the primary fuse programming block: register offsets, field positions,
 * page codes, reset values and the fuse burn time.
 * Assumes byte-wide registers reached through the paged management register port.
 */
package fuse_prog_pkg;
    localparam logic [7:0] PAGE_SEL_ADDR = 8'hff;
    localparam logic [7:0] FUSE_CMD_ADDR = 8'h0f;
    localparam logic [7:0] LOCK_WAKE_ADDR = 8'h2f;
    localparam logic [7:0] FORCE_OVR_ADDR = 8'he0;
    localparam logic [7:0] PWR_EN_ADDR = 8'he1;
    localparam int NUM_SUBSYS = 7;
    localparam int NUM_PAGES = 8;
    localparam int LOCK_MSB = 7;
    localparam int LOCK_LSB = 6;
    localparam logic [1:0] LOCK_VALUE = 2'h1;
    localparam int WAKE_OFF_BIT = 4;
    localparam int CMD_MSB = 7;
    localparam int CMD_LSB = 3;
    localparam logic [4:0] FUSE_WRITE_CMD = 5'h0c;
    localparam logic [7:0] FUSE_WRITE_BYTE = 8'hc0;
    localparam int BUSY_BIT = 0;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam int BURN_CYCLES = 64;
    localparam logic [2:0] MASTER_IDX = 3'h0;

    // Page code to storage slot: 0,1,2,3 then a..d as 4..7; bit 3 flags a legal code.
    function automatic logic [3:0] page_slot(input logic [7:0] code);
        logic [3:0] r;
        r = 4'h0;
        if (code <= 8'h03) begin
            r = {1'b1, code[2:0]};
        end else if (code >= 8'h0a && code <= 8'h0d) begin
            r = {1'b1, 3'(code[2:0] + 3'h2)};
        end
        return r;
    endfunction

    // Subsystem bit (input, clock monitor, output, pll a..d) served by a slot; bit 3 flags a slave page.
    function automatic logic [3:0] slot_subsys(input logic [2:0] slot);
        logic [3:0] r;
        case (slot)
            3'h1: r = 4'h9;
            3'h2: r = 4'h8;
            3'h3: r = 4'ha;
            3'h4: r = 4'hb;
            3'h5: r = 4'hc;
            3'h6: r = 4'hd;
            3'h7: r = 4'he;
            default: r = 4'h0;
        endcase
        return r;
    endfunction
endpackage

// >>> hw/page_store_if.sv
/*
 * Carrier between the fuse control logic and its per-page register store.
 * Assumes both ends share ref_clk.
 */
`timescale 1ns/1ps
interface page_store_if;
    logic wrEn;
    logic selLock;
    logic [2:0] slot;
    logic [7:0] wrData;
    logic [7:0] cmdData;
    logic [7:0] lockData;
    logic [7:0] lockedVec;
    modport ctrl (output wrEn, output selLock, output slot, output wrData,
        input cmdData, input lockData, input lockedVec);
    modport store (input wrEn, input selLock, input slot, input wrData,
        output cmdData, output lockData, output lockedVec);
endinterface

// >>> hw/page_reg_store.sv
/*
 * Per-page copies of the fuse command and lock/wake registers, one byte each for eight pages.
 * Read data are registered, so they follow a change of slot one clock later.
 * Assumes ref_clk and an asynchronous active-high rst.
 */
`timescale 1ns/1ps
module page_reg_store (
    input wire logic ref_clk,
    input wire logic rst,
    page_store_if.store bus
);
    import fuse_prog_pkg::*;

    logic [7:0] cmdMem_r [NUM_PAGES];
    logic [7:0] lockMem_r [NUM_PAGES];
    logic [7:0] cmdMem_nxt [NUM_PAGES];
    logic [7:0] lockMem_nxt [NUM_PAGES];
    logic [7:0] cmdData_r;
    logic [7:0] lockData_r;
    logic [7:0] lockedVec_r;
    logic [7:0] lockedVec_nxt;

    always_comb begin
        cmdMem_nxt = cmdMem_r;
        lockMem_nxt = lockMem_r;
        if (bus.wrEn && !bus.selLock) begin
            cmdMem_nxt[bus.slot] = bus.wrData;
        end
        if (bus.wrEn && bus.selLock) begin
            // The lock field is one-time: once locked it no longer takes writes.
            lockMem_nxt[bus.slot] = bus.wrData;
            if (lockedVec_r[bus.slot]) begin
                lockMem_nxt[bus.slot][LOCK_MSB:LOCK_LSB] = LOCK_VALUE;
            end
        end
        for (int i = 0; i < NUM_PAGES; i++) begin
            lockedVec_nxt[i] = lockMem_nxt[i][LOCK_MSB:LOCK_LSB] == LOCK_VALUE;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_PAGES; i++) begin
                cmdMem_r[i] <= REG_RESET;
                lockMem_r[i] <= REG_RESET;
            end
            cmdData_r <= REG_RESET;
            lockData_r <= REG_RESET;
            lockedVec_r <= 8'h00;
        end else begin
            cmdMem_r <= cmdMem_nxt;
            lockMem_r <= lockMem_nxt;
            cmdData_r <= cmdMem_r[bus.slot];
            lockData_r <= lockMem_r[bus.slot];
            lockedVec_r <= lockedVec_nxt;
        end
    end

    assign bus.cmdData = cmdData_r;
    assign bus.lockData = lockData_r;
    assign bus.lockedVec = lockedVec_r;
endmodule

// >>> tb/fuse_prog_monitor.sv
/*
 * Port checker for the primary fuse programming block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module fuse_prog_monitor import fuse_prog_pkg::*; #(
    parameter int BURN_LEN = BURN_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic regRdValid,
    input wire logic [fuse_prog_pkg::NUM_SUBSYS-1:0] forceOverride,
    input wire logic [fuse_prog_pkg::NUM_SUBSYS-1:0] subsysPowerEn,
    input wire logic manualWakeMode,
    input wire logic fuseWriteStart,
    input wire logic [2:0] fuseWritePage,
    input wire logic fuseWriteBusy
);
    int busyCnt_r;
    int busyCnt_nxt;
    logic [6:0] wrLow;
    assign wrLow = regWrData[6:0];
    always_comb busyCnt_nxt = fuseWriteBusy ? busyCnt_r + 1 : 0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) busyCnt_r <= 0;
        else busyCnt_r <= busyCnt_nxt;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_start_busy: assert property (fuseWriteStart |-> fuseWriteBusy)
        else $error("start without busy");
    chk_start_pulse: assert property (fuseWriteStart |=> !fuseWriteStart)
        else $error("start longer than one cycle");
    chk_busy_cause: assert property ($rose(fuseWriteBusy) |-> fuseWriteStart)
        else $error("busy without start");
    chk_burn_length: assert property ($fell(fuseWriteBusy) |-> busyCnt_r == BURN_LEN)
        else $error("burn length wrong");
    chk_cmd_cause: assert property (fuseWriteStart |-> $past(regWrEn) && $past(regAddr) == FUSE_CMD_ADDR
        && ($past(regWrData) == FUSE_WRITE_BYTE || ($past(regWrData) & 8'hf8) == {FUSE_WRITE_CMD, 3'h0}))
        else $error("start without command");
    chk_wake_hold: assert property (fuseWriteBusy |-> manualWakeMode)
        else $error("auto wake during burn");
    chk_page_hold: assert property (fuseWriteBusy && !fuseWriteStart |-> $stable(fuseWritePage))
        else $error("burn page moved");
    chk_rd_answer: assert property (regRdEn |=> regRdValid)
        else $error("read not answered");
    chk_force_cause: assert property ($changed(forceOverride) |-> $past(regWrEn)
        && $past(regAddr) == FORCE_OVR_ADDR && forceOverride == $past(wrLow))
        else $error("override changed wrongly");
    chk_power_cause: assert property ($changed(subsysPowerEn) |-> $past(regWrEn)
        && $past(regAddr) == PWR_EN_ADDR && subsysPowerEn == $past(wrLow))
        else $error("enable changed wrongly");
endmodule

// >>> tb/host_model.sv
/*
 * Behavioural host on the byte register port.
 * Assumes the device answers a read with a valid pulse one cycle later.
 */
`timescale 1ns/1ps
module host_model (
    input wire logic ref_clk,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn
);
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end
    // Released data shows the inverse so a stale byte cannot pass as fresh.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        regWrData <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge ref_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (regRdValid !== 1'b1 && n < 4);
        d = regRdData;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
endmodule

// >>> tb/testbench.sv
/*
 * Self-checking bench: host model drives the port, a small model predicts results.
 * Assumes a short burn length parameter.
 */
`timescale 1ns/1ps
module testbench;
    import fuse_prog_pkg::*;
    localparam int BL = 4;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr, regWrData, regRdData, rv;
    logic regWrEn, regRdEn, regRdValid, manualWakeMode, fuseWriteStart, fuseWriteBusy;
    logic [6:0] forceOverride, subsysPowerEn, force_m;
    logic [2:0] fuseWritePage, lastPage;
    logic [7:0] pages [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
    int fails = 0;
    int total_checks = 0;
    int starts = 0;
    int expStarts = 0;
    int seed = 32'hbfd178c0;
    always #4 ref_clk = ~ref_clk;
    primary_fuse_programming #(.BURN_LEN(BL)) dut_u (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .forceOverride(forceOverride), .subsysPowerEn(subsysPowerEn),
        .manualWakeMode(manualWakeMode), .fuseWriteStart(fuseWriteStart),
        .fuseWritePage(fuseWritePage), .fuseWriteBusy(fuseWriteBusy));
    host_model host_u (.ref_clk(ref_clk), .regRdData(regRdData), .regRdValid(regRdValid),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn));
    always @(posedge ref_clk) begin
        if (fuseWriteStart === 1'b1) begin
            starts++;
            lastPage <= fuseWritePage;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (fails == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic burn(input logic [7:0] cmd);
        host_u.wr(FUSE_CMD_ADDR, 8'h00);
        host_u.wr(FUSE_CMD_ADDR, cmd);
        host_u.wr(FUSE_CMD_ADDR, 8'h00);
        host_u.idle(BL + 4);
    endtask
    initial begin
        #200000;
        fails++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        check({1'b0, forceOverride}, 8'h00);
        check({7'h0, manualWakeMode}, 8'h01);
        host_u.rd(PAGE_SEL_ADDR, rv);
        check(rv, PAGE_RESET);
        host_u.rd(8'h55, rv);
        check(rv, 8'h00);
        burn(FUSE_WRITE_BYTE);
        check(8'(starts), 8'h01);
        for (int k = 0; k < 4; k++) begin
            force_m = 7'($random(seed));
            host_u.wr(FORCE_OVR_ADDR, {1'b0, force_m});
            host_u.wr(PWR_EN_ADDR, {1'b1, ~force_m});
            host_u.idle(1);
            check({1'b0, forceOverride}, {1'b0, force_m});
            check({1'b0, subsysPowerEn}, {1'b0, ~force_m});
            host_u.rd(FORCE_OVR_ADDR, rv);
            check(rv, {1'b0, force_m});
        end
        host_u.wr(FORCE_OVR_ADDR, 8'h7f);
        host_u.wr(PWR_EN_ADDR, 8'h7f);
        expStarts = 1;
        for (int i = 1; i < 8; i++) begin
            host_u.wr(PAGE_SEL_ADDR, pages[i]);
            host_u.rd(PAGE_SEL_ADDR, rv);
            check(rv, pages[i]);
            host_u.rd(PWR_EN_ADDR, rv);
            check(rv, 8'h00);
            host_u.wr(FORCE_OVR_ADDR, 8'h00);
            burn(i == 4 ? 8'h60 : FUSE_WRITE_BYTE);
            expStarts++;
            check(8'(starts), 8'(expStarts));
            check({5'h0, lastPage}, 8'(i));
            check({1'b0, forceOverride}, 8'h7f);
            host_u.wr(LOCK_WAKE_ADDR, 8'h40);
            host_u.rd(LOCK_WAKE_ADDR, rv);
            check(rv, 8'h40);
            burn(FUSE_WRITE_BYTE);
            check(8'(starts), 8'(expStarts));
        end
        host_u.wr(PAGE_SEL_ADDR, 8'h05);
        host_u.rd(PAGE_SEL_ADDR, rv);
        check(rv, 8'h0d);
        host_u.wr(PAGE_SEL_ADDR, 8'h00);
        check({7'h0, manualWakeMode}, 8'h01);
        host_u.wr(LOCK_WAKE_ADDR, 8'h10);
        host_u.idle(1);
        check({7'h0, manualWakeMode}, 8'h00);
        host_u.wr(FUSE_CMD_ADDR, 8'h00);
        host_u.wr(FUSE_CMD_ADDR, FUSE_WRITE_BYTE);
        host_u.idle(1);
        check({7'h0, manualWakeMode}, 8'h01);
        check({7'h0, fuseWriteBusy}, 8'h01);
        host_u.rd(FUSE_CMD_ADDR, rv);
        check(rv, FUSE_WRITE_BYTE | 8'h01);
        host_u.wr(FUSE_CMD_ADDR, 8'h00);
        host_u.idle(BL + 4);
        expStarts++;
        check(8'(starts), 8'(expStarts));
        check({5'h0, lastPage}, 8'h00);
        check({7'h0, manualWakeMode}, 8'h00);
        host_u.wr(LOCK_WAKE_ADDR, 8'h50);
        burn(FUSE_WRITE_BYTE);
        check(8'(starts), 8'(expStarts));
        check({7'h0, manualWakeMode}, 8'h00);
        rst <= 1'b1;
        host_u.idle(2);
        rst <= 1'b0;
        host_u.idle(1);
        check({1'b0, subsysPowerEn}, 8'h00);
        check({7'h0, manualWakeMode}, 8'h01);
        conclude();
    end
endmodule
bind primary_fuse_programming fuse_prog_monitor #(.BURN_LEN(BURN_LEN)) mon_u (.ref_clk(ref_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdValid(regRdValid), .forceOverride(forceOverride), .subsysPowerEn(subsysPowerEn),
    .manualWakeMode(manualWakeMode), .fuseWriteStart(fuseWriteStart),
    .fuseWritePage(fuseWritePage), .fuseWriteBusy(fuseWriteBusy));
